// ---- inc/charge_time_cfg.svh ----
// Address map, bit positions and reset values of the charge time unit
`ifndef CHARGE_TIME_CFG_SVH
`define CHARGE_TIME_CFG_SVH
`define CT_A_CTRL 8'h00
`define CT_A_EDGE 8'h04
`define CT_A_STAT 8'h08
`define CT_A_MASK 8'h0C
`define CT_A_LIVE 8'h10
`define CT_B_EN 0
`define CT_B_HALT 1
`define CT_B_PULSE 2
`define CT_B_EDGEN 3
`define CT_B_SEQ 4
`define CT_B_GND 5
`define CT_B_F1 0
`define CT_B_F2 1
`define CT_E_EDGE1 0
`define CT_E_EDGE2 1
`define CT_E_TRIP 2
`define CT_L_SRC 0
`define CT_L_GND 1
`define CT_L_PULSE 2
`define CT_L_SLEEP 3
`define CT_L_IDLE 4
`define CT_RST_CTRL 6'h00
`define CT_RST_EVT 3'h0
`define CT_RESP_OK 2'h0
`define CT_RESP_ERR 2'h2
`define CT_ZERO32 32'h0000_0000
`endif

// ---- inc/charge_time_pkg.sv ----
// Types shared by the charge time unit modules
package charge_time_pkg;
  typedef enum logic {WR_IDLE, WR_RESP} wr_e;
  typedef struct packed {
    logic f1;
    logic f2;
  } flags_s;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [2:0] stat;
    logic [2:0] mask;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    wr_e wr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic e1_d;
    logic e2_d;
    logic trip_d;
  } main_s;
endpackage : charge_time_pkg

// ---- inc/edge_flags_if.sv ----
// Signals between the control block and the edge flag holder
`timescale 1ns/1ps
interface edge_flags_if;
  logic wr;
  logic [1:0] wdata;
  logic ev1;
  logic ev2;
  logic seq_en;
  logic f1;
  logic f2;
  logic set1;
  logic set2;
  modport ctrl (output wr, wdata, ev1, ev2, seq_en, input f1, f2, set1, set2);
  modport flags (input wr, wdata, ev1, ev2, seq_en, output f1, f2, set1, set2);
endinterface : edge_flags_if

// ---- verification/analog_front_end.sv ----
// Behavioural current source node and comparator
`timescale 1ns/1ps
module analog_front_end #(
  parameter int TRIP_LEVEL = 30
) (
  input wire logic clk,
  input wire logic source_on,
  input wire logic source_ground,
  output logic comparator_trip
);
  int charge = 0;
  always @(posedge clk) begin
    if (source_ground) charge <= 0;
    else if (source_on) charge <= charge + 1;
  end
  assign comparator_trip = (charge >= TRIP_LEVEL);
endmodule : analog_front_end

// ---- verification/charge_time_properties.sv ----
// Port level checks of the charge time unit
`timescale 1ns/1ps
module charge_time_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic edge1_in,
  input wire logic edge2_in,
  input wire logic comparator_trip,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic s_axi_bvalid,
  input wire logic source_on,
  input wire logic source_ground,
  input wire logic pulse_output_pin,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_sleep_src_off: assert property (sleep_mode |-> !source_on)
    else $error("source on during sleep");
  a_sleep_pulse_off: assert property (sleep_mode |-> !pulse_output_pin)
    else $error("pulse during sleep");
  a_ground_blocks_src: assert property (source_ground |-> !source_on)
    else $error("source charges while grounded");
  a_trip_ends_pulse: assert property (comparator_trip |-> !pulse_output_pin)
    else $error("pulse stays after trip");
  a_trip_pulse_now: assert property ($rose(comparator_trip) && $past(pulse_output_pin)
    |-> !pulse_output_pin)
    else $error("pulse end waits for clock");
  a_pulse_needs_src: assert property (pulse_output_pin && !source_ground |-> source_on)
    else $error("pulse without charging");
  a_reset_clears: assert property (disable iff (1'b0) rst |=> !source_on && !source_ground
    && !pulse_output_pin && !irq)
    else $error("outputs not cleared by reset");
  a_src_steady: assert property (!$rose(s_axi_bvalid) && $stable(sleep_mode)
    && $stable(idle_mode) && $stable(comparator_trip) && !$past(rst)
    && $past(comparator_trip, 2) == comparator_trip && !edge1_in && !$past(edge1_in)
    && !$past(edge1_in, 2) && !edge2_in && !$past(edge2_in) && !$past(edge2_in, 2)
    |-> $stable(source_on))
    else $error("source changed without cause");
endmodule : charge_time_properties
bind charge_time_unit charge_time_properties chk (.clk(clk), .rst(rst),
  .edge1_in(edge1_in), .edge2_in(edge2_in), .comparator_trip(comparator_trip),
  .sleep_mode(sleep_mode), .idle_mode(idle_mode), .s_axi_bvalid(s_axi_bvalid),
  .source_on(source_on), .source_ground(source_ground),
  .pulse_output_pin(pulse_output_pin), .irq(irq));

// ---- verification/tb.sv ----
// Register level tests of the charge time unit
`timescale 1ns/1ps
`include "charge_time_cfg.svh"
module tb
  import charge_time_pkg::*;
;
  logic clk = 0, rst = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic edge1_in = 0, edge2_in = 0, sleep_mode = 0, idle_mode = 0;
  logic trip, src, gnd, pls, irq;
  int failures = 0, n_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  charge_time_unit uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .edge1_in(edge1_in), .edge2_in(edge2_in),
    .comparator_trip(trip), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .source_on(src), .source_ground(gnd), .pulse_output_pin(pls), .irq(irq));
  analog_front_end afe (.clk(clk), .source_on(src), .source_ground(gnd),
    .comparator_trip(trip));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      if (b_hs) rsp = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end while (!b_hs);
    bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic ar_hs, r_hs;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      if (r_hs) begin
        rd = rdata;
        rsp = rresp;
      end
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
    end while (!r_hs);
    rready <= 1'b0;
    chk("read data", e, rd);
  endtask : rc
  task automatic kick(input int which);
    if (which == 1) edge1_in <= 1'b1;
    else edge2_in <= 1'b1;
    repeat (2) @(posedge clk);
    edge1_in <= 1'b0;
    edge2_in <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : kick
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc(`CT_A_CTRL, 32'h0);
    rc(`CT_A_EDGE, 32'h0);
    chk("source", 1'b0, src);
    wr(`CT_A_CTRL, 32'h01);
    wr(`CT_A_EDGE, 32'h01);
    chk("source", 1'b1, src);
    wr(`CT_A_EDGE, 32'h03);
    chk("source", 1'b0, src);
    wr(`CT_A_EDGE, 32'h00);
    chk("source", 1'b0, src);
    wr(`CT_A_CTRL, 32'h00);
    wr(`CT_A_EDGE, 32'h01);
    chk("source", 1'b0, src);
    wr(`CT_A_CTRL, 32'h21);
    chk("ground", 1'b1, gnd);
    chk("source", 1'b0, src);
    wr(`CT_A_CTRL, 32'h01);
    chk("source", 1'b1, src);
    sleep_mode <= 1'b1;
    @(posedge clk);
    chk("source", 1'b0, src);
    sleep_mode <= 1'b0;
    idle_mode <= 1'b1;
    @(posedge clk);
    chk("source", 1'b1, src);
    rc(`CT_A_LIVE, 32'h11);
    wr(`CT_A_CTRL, 32'h03);
    chk("source", 1'b0, src);
    idle_mode <= 1'b0;
    wr(`CT_A_CTRL, 32'h09);
    wr(`CT_A_EDGE, 32'h00);
    kick(1);
    chk("source", 1'b1, src);
    chk("irq", 1'b0, irq);
    rc(`CT_A_STAT, 32'h1);
    kick(2);
    chk("source", 1'b0, src);
    rc(`CT_A_STAT, 32'h2);
    wr(`CT_A_EDGE, 32'h00);
    wr(`CT_A_CTRL, 32'h21);
    wr(`CT_A_MASK, 32'h04);
    wr(`CT_A_CTRL, 32'h05);
    chk("pulse", 1'b0, pls);
    wr(`CT_A_EDGE, 32'h01);
    chk("pulse", 1'b1, pls);
    for (int i = 0; i < 100 && pls; i++) @(negedge clk);
    chk("trip", 1'b1, trip);
    chk("pulse", 1'b0, pls);
    repeat (3) @(posedge clk);
    chk("irq", 1'b1, irq);
    chk("source", 1'b0, src);
    rc(`CT_A_STAT, 32'h6);
    chk("irq", 1'b0, irq);
    wr(8'h40, 32'h0);
    chk("write resp", `CT_RESP_ERR, rsp);
    rc(8'h40, 32'h0);
    chk("read resp", `CT_RESP_ERR, rsp);
    tally_and_finish;
  end
endmodule : tb

// ---- verilog/charge_time_unit.sv ----
// Charge time unit control with AXI4-Lite register slave
// Notes on behaviour
// - Setting the first edge flag starts charging and clearing it stops charging.
// - Charging starts at the first edge event and stops at the second edge event.
// - With the unit enabled, the ground control ties the source output to ground; it holds source_on off while it is set.
// - The delay pulse enable selects pulse mode with comparator 2 and its reference.
// - In pulse mode the output pulse starts on a clock edge; its end at comparator trip does not depend on the system clock.
// - In pulse mode the comparator trip ends the pulse on the pulse output pin.
// - Any sleep mode forces the current source off.
// - With idle halt clear the unit keeps running in Idle.
// - With idle halt set the source is disabled on Idle entry.
// - Any reset clears all control state, leaving the unit off.
`timescale 1ns/1ps
`include "charge_time_cfg.svh"
module charge_time_unit
  import charge_time_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic edge1_in,
  input wire logic edge2_in,
  input wire logic comparator_trip,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  output logic source_on,
  output logic source_ground,
  output logic pulse_output_pin,
  output logic irq
);
  main_s st_r;
  main_s st_nxt;
  edge_flags_if fl ();

  logic unit_enable;
  logic idle_halt_select;
  logic delay_pulse_enable;
  logic edge_enable;
  logic seq_enable;
  logic source_ground_control;
  logic source_allowed;
  logic trip_rise;
  logic [2:0] events;
  logic wr_do;
  logic rd_do;
  logic [31:0] ctrl_word;
  logic [31:0] live_word;

  edge_flags u_flags (
    .clk(clk),
    .rst(rst),
    .fl(fl)
  );

  assign unit_enable = st_r.ctrl[`CT_B_EN];
  assign idle_halt_select = st_r.ctrl[`CT_B_HALT];
  assign delay_pulse_enable = st_r.ctrl[`CT_B_PULSE];
  assign edge_enable = st_r.ctrl[`CT_B_EDGEN];
  assign seq_enable = st_r.ctrl[`CT_B_SEQ];
  assign source_ground_control = st_r.ctrl[`CT_B_GND];

  assign source_allowed = ~sleep_mode & ~(idle_mode & idle_halt_select);

  assign source_on = unit_enable & fl.f1 & ~fl.f2 & source_allowed
                     & ~source_ground_control;

  assign source_ground = unit_enable & source_ground_control;

  assign pulse_output_pin = unit_enable & delay_pulse_enable & fl.f1 & ~fl.f2
                            & ~comparator_trip & source_allowed;

  // Comparator trip rise in pulse mode
  assign trip_rise = comparator_trip & ~st_r.trip_d & unit_enable
                     & delay_pulse_enable;

  assign fl.ev1 = unit_enable & edge_enable & edge1_in & ~st_r.e1_d;
  assign fl.ev2 = (unit_enable & edge_enable & edge2_in & ~st_r.e2_d) | trip_rise;
  assign fl.seq_en = seq_enable;

  assign events = {trip_rise, fl.set2, fl.set1};

  assign wr_do = st_r.aw_got & st_r.w_got & (st_r.wr == WR_IDLE);
  assign rd_do = s_axi_arvalid & ~st_r.rvalid;

  assign fl.wr = wr_do & (st_r.awaddr == `CT_A_EDGE) & st_r.wstrb[0];
  assign fl.wdata = st_r.wdata[1:0];

  // Handshake outputs
  assign s_axi_awready = ~st_r.aw_got;
  assign s_axi_wready = ~st_r.w_got;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // Interrupt from masked sticky events
  assign irq = |(st_r.stat & st_r.mask);

  always_comb begin
    ctrl_word = `CT_ZERO32;
    ctrl_word[5:0] = st_r.ctrl;
    live_word = `CT_ZERO32;
    live_word[`CT_L_SRC] = source_on;
    live_word[`CT_L_GND] = source_ground;
    live_word[`CT_L_PULSE] = pulse_output_pin;
    live_word[`CT_L_SLEEP] = sleep_mode;
    live_word[`CT_L_IDLE] = idle_mode;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.e1_d = edge1_in;
    st_nxt.e2_d = edge2_in;
    st_nxt.trip_d = comparator_trip;

    // Write address and data capture
    if (s_axi_awvalid & ~st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end

    // Write decode and response
    case (st_r.wr)
      WR_IDLE: begin
        if (wr_do) begin
          st_nxt.wr = WR_RESP;
          st_nxt.bvalid = 1'b1;
          st_nxt.bresp = `CT_RESP_OK;
          if (st_r.awaddr == `CT_A_CTRL) begin
            if (st_r.wstrb[0]) begin
              st_nxt.ctrl = st_r.wdata[5:0];
            end
          end else if (st_r.awaddr == `CT_A_MASK) begin
            if (st_r.wstrb[0]) begin
              st_nxt.mask = st_r.wdata[2:0];
            end
          end else if (st_r.awaddr == `CT_A_EDGE) begin
            st_nxt.bresp = `CT_RESP_OK;
          end else if (st_r.awaddr == `CT_A_STAT) begin
            st_nxt.bresp = `CT_RESP_OK;
          end else if (st_r.awaddr == `CT_A_LIVE) begin
            st_nxt.bresp = `CT_RESP_OK;
          end else begin
            st_nxt.bresp = `CT_RESP_ERR;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          st_nxt.wr = WR_IDLE;
          st_nxt.bvalid = 1'b0;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
        end
      end
      default: begin
        st_nxt.wr = WR_IDLE;
      end
    endcase

    // Read decode
    if (st_r.rvalid & s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_do) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `CT_RESP_OK;
      st_nxt.rdata = `CT_ZERO32;
      if (s_axi_araddr == `CT_A_CTRL) begin
        st_nxt.rdata = ctrl_word;
      end else if (s_axi_araddr == `CT_A_EDGE) begin
        st_nxt.rdata[`CT_B_F1] = fl.f1;
        st_nxt.rdata[`CT_B_F2] = fl.f2;
      end else if (s_axi_araddr == `CT_A_STAT) begin
        st_nxt.rdata[2:0] = st_r.stat;
        st_nxt.stat = `CT_RST_EVT;
      end else if (s_axi_araddr == `CT_A_MASK) begin
        st_nxt.rdata[2:0] = st_r.mask;
      end else if (s_axi_araddr == `CT_A_LIVE) begin
        st_nxt.rdata = live_word;
      end else begin
        st_nxt.rresp = `CT_RESP_ERR;
      end
    end

    // Sticky events, set wins over read clear
    st_nxt.stat = st_nxt.stat | events;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctrl <= `CT_RST_CTRL;
      st_r.stat <= `CT_RST_EVT;
      st_r.mask <= `CT_RST_EVT;
      st_r.wr <= WR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : charge_time_unit

// ---- verilog/edge_flags.sv ----
// Holder of the first and second edge flags
`timescale 1ns/1ps
`include "charge_time_cfg.svh"
module edge_flags
  import charge_time_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  edge_flags_if.flags fl
);
  flags_s st_r;
  flags_s st_nxt;

  // Second edge waits for first when sequenced
  assign fl.set1 = fl.ev1;
  assign fl.set2 = fl.ev2 & (~fl.seq_en | st_r.f1);
  assign fl.f1 = st_r.f1;
  assign fl.f2 = st_r.f2;

  always_comb begin
    st_nxt = st_r;
    if (fl.wr) begin
      st_nxt.f1 = fl.wdata[`CT_B_F1];
      st_nxt.f2 = fl.wdata[`CT_B_F2];
    end
    if (fl.set1) begin
      st_nxt.f1 = 1'b1;
    end
    if (fl.set2) begin
      st_nxt.f2 = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : edge_flags
